// ---- src/wdg_pkg.sv ----
// package for the watchdog timer block
// assumes a single 100 MHz clock and an Avalon-MM register slave
package wdg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] WATCHDOG_CONTROL_OFS  = 8'h14; // byte address
  localparam logic [7:0] MISC_CONFIG_THREE_OFS = 8'h18; // byte address
  localparam logic [7:0] STATUS_OFS            = 8'h1c; // byte address
  localparam logic [7:0] CTRL_RESET            = 8'h7f;
  localparam logic [7:0] MISC_RESET            = 8'h00;
  localparam int         ACT_BIT               = 7;
  localparam int         MSB_BIT               = 6;
  localparam int         HALT_PERMIT_BIT       = 7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PRESCALE_CYCLES  = 65536; // machine cycles per step
  localparam int CLK_MHZ          = 100;
  localparam int RESET_PULSE_NS   = 500;
  localparam int RESET_PULSE_CYC  = (RESET_PULSE_NS * CLK_MHZ) / 1000;
  localparam int WAKE_DELAY_CLKS  = 514;

  // ----------------------------------------------------------------
  // power-mode status carried together
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wait_mode;
    logic halt_exec;   // one-cycle pulse on halt instruction
    logic osc_stopped;
    logic ext_wake;    // one-cycle pulse on external interrupt
    logic usb_suspend;
  } power_s;

endpackage

// ---- src/watchdog_timer.sv ----
// watchdog timer with 7-bit downcounter and reset pulse generator
// assumes power-mode signals synchronous to CLK, one machine cycle per CLK
//
// Operation
// [RULE1] counter drops by one every 65536 machine cycles; 64 timeout steps
// [RULE2] active watchdog resets when counter goes from 40h to 3Fh
// [RULE3] expiry drives the reset pin low for about 500 ns
// [RULE4] counter keeps running even when watchdog is off
// [RULE5] software writes values C0h to FFh into the control register
// [RULE6] software refreshes control register before the counter msb clears
// [RULE7] at 8 MHz FFh gives 524.288 ms and C0h gives 8.192 ms
// [RULE8] software option comes out of every reset deactivated
// [RULE9] activation bit once set ignores clears until reset
// [RULE10] writing active with msb clear forces an immediate reset
// [RULE11] hardware option keeps watchdog always active
// [RULE12] wait mode changes nothing
// [RULE13] halt with stopped oscillator freezes counter and blocks resets
// [RULE14] after external wake, counting resumes 514 clocks later
// [RULE15] no watchdog reset on halt entry during usb suspend
// [RULE16] control register: bit 7 activation, bits 6:0 countdown
// [RULE17] control register resets to 7Fh
// [RULE18] software should refresh the counter before halt
// [RULE19] halt without permit while active resets, except in usb suspend
// [RULE20] write to control register loads counter at once
module watchdog_timer #(
  parameter int PRESCALE = wdg_pkg::PRESCALE_CYCLES,
  parameter int WAKE_DLY = wdg_pkg::WAKE_DELAY_CLKS
) (
  input  wire logic          CLK,
  input  wire logic          RST,
  input  wire logic          HW_OPTION,
  input  wire wdg_pkg::power_s PWR,
  input  wire logic [7:0]    AVS_ADDRESS,
  input  wire logic          AVS_READ,
  input  wire logic          AVS_WRITE,
  input  wire logic [31:0]   AVS_WRITEDATA,
  input  wire logic [3:0]    AVS_BYTEENABLE,
  output logic [31:0]        AVS_READDATA,
  output logic               AVS_WAITREQUEST,
  output logic               WDG_RESET_N
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the wake delay check below unrolls eight cycles, so shorter delays are refused
  if (PRESCALE < 2 || WAKE_DLY < 8) begin : g_bad_params
    $error("watchdog_timer: bad prescale or wake delay");
  end

  localparam int PW  = $clog2(PRESCALE);
  localparam int WW  = $clog2(WAKE_DLY + 1);
  localparam int RW  = $clog2(wdg_pkg::RESET_PULSE_CYC + 1);
  localparam logic [PW-1:0] PRE_LAST  = PW'(PRESCALE - 1);
  localparam logic [WW-1:0] WAKE_LOAD = WW'(WAKE_DLY);
  localparam logic [RW-1:0] PULSE_LD  = RW'(wdg_pkg::RESET_PULSE_CYC);

  typedef enum logic [1:0] {RUN, HALTED, WAKING} pmode_e;

  logic [6:0]    count_ff;
  logic          act_ff;
  logic          permit_ff;
  logic [PW-1:0] pre_ff;
  logic [WW-1:0] wake_ff;
  logic [RW-1:0] pulse_ff;
  pmode_e        mode_ff;
  logic          ack_ff;
  logic          hw_ff;

  logic acc, wr_ctrl, wr_misc, step, active, frozen, halt_hit, expire, soft_rst;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign acc     = (AVS_READ | AVS_WRITE) & ~ack_ff;
  // writes land at the edge where the master sees waitrequest low
  assign wr_ctrl = ack_ff & AVS_WRITE & AVS_BYTEENABLE[0]
                   & (AVS_ADDRESS == wdg_pkg::WATCHDOG_CONTROL_OFS);
  assign wr_misc = ack_ff & AVS_WRITE & AVS_BYTEENABLE[0]
                   & (AVS_ADDRESS == wdg_pkg::MISC_CONFIG_THREE_OFS);

  // option strap caught by clock after reset release
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hw_ff <= 1'b0;
    end else begin
      hw_ff <= HW_OPTION;
    end
  end

  // ----------------------------------------------------------------
  // power mode and gating
  // ----------------------------------------------------------------
  assign active = hw_ff | act_ff;                                  // see [RULE11]
  assign frozen = (mode_ff != RUN);                                // see [RULE13]
  assign step   = ~frozen & (pre_ff == PRE_LAST);                  // see [RULE1] [RULE12]
  assign halt_hit = PWR.halt_exec & active & ~permit_ff
                    & ~PWR.usb_suspend & ~frozen;                  // see [RULE19] [RULE15]
  assign soft_rst = wr_ctrl & AVS_WRITEDATA[wdg_pkg::ACT_BIT]
                    & ~AVS_WRITEDATA[wdg_pkg::MSB_BIT];            // see [RULE10]
  assign expire = active & step & (count_ff == 7'h40);             // see [RULE2]

  // halt / wake sequencing
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_ff <= RUN;
      wake_ff <= '0;
    end else begin
      unique case (mode_ff)
        RUN: begin
          if (PWR.halt_exec & PWR.osc_stopped & ~halt_hit) begin
            mode_ff <= HALTED;                                     // see [RULE13]
          end
        end
        HALTED: begin
          if (PWR.ext_wake) begin
            mode_ff <= WAKING;
            wake_ff <= WAKE_LOAD;                                  // see [RULE14]
          end
        end
        WAKING: begin
          if (wake_ff == WW'(1)) begin
            mode_ff <= RUN;
          end
          wake_ff <= wake_ff - WW'(1);
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // prescaler and counter
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pre_ff <= '0;
    end else if (!frozen) begin
      pre_ff <= (pre_ff == PRE_LAST) ? '0 : pre_ff + PW'(1);       // see [RULE4]
    end
  end

  // countdown, loaded by write
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      count_ff <= wdg_pkg::CTRL_RESET[6:0];                        // see [RULE17]
    end else if (wr_ctrl) begin
      count_ff <= AVS_WRITEDATA[6:0];                              // see [RULE20] [RULE16]
    end else if (step) begin
      count_ff <= count_ff - 7'h01;                                // see [RULE4] [RULE7]
    end
  end

  // activation bit, set only
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      act_ff <= wdg_pkg::CTRL_RESET[wdg_pkg::ACT_BIT];             // see [RULE8]
    end else if (wr_ctrl & AVS_WRITEDATA[wdg_pkg::ACT_BIT]) begin
      act_ff <= 1'b1;                                              // see [RULE9]
    end
  end

  // halt permit bit
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      permit_ff <= wdg_pkg::MISC_RESET[wdg_pkg::HALT_PERMIT_BIT];
    end else if (wr_misc) begin
      permit_ff <= AVS_WRITEDATA[wdg_pkg::HALT_PERMIT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // reset pulse generator
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pulse_ff    <= '0;
      WDG_RESET_N <= 1'b1;
    end else if (expire | soft_rst | halt_hit) begin
      pulse_ff    <= PULSE_LD;                                     // see [RULE3]
      WDG_RESET_N <= 1'b0;
    end else if (pulse_ff != '0) begin
      pulse_ff    <= pulse_ff - RW'(1);
      WDG_RESET_N <= (pulse_ff == RW'(1));
    end
  end

  // ----------------------------------------------------------------
  // bus answer: one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_ff          <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= '0;
    end else begin
      ack_ff          <= acc;
      AVS_WAITREQUEST <= ~acc;
      if (acc & AVS_READ) begin
        unique case (AVS_ADDRESS)
          wdg_pkg::WATCHDOG_CONTROL_OFS: AVS_READDATA <= {24'h0, act_ff, count_ff};
          wdg_pkg::MISC_CONFIG_THREE_OFS: AVS_READDATA <= {24'h0, permit_ff, 7'h00};
          wdg_pkg::STATUS_OFS: AVS_READDATA <= {29'h0, hw_ff, frozen, active};
          default: AVS_READDATA <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_expire_pulse;
    @(posedge CLK) disable iff (RST) expire |=> !WDG_RESET_N;
  endproperty
  a_expire_pulse: assert property (p_expire_pulse) else $error("no reset on expiry"); // see [RULE2]

  property p_pulse_len;
    @(posedge CLK) disable iff (RST)
      $fell(WDG_RESET_N) && !expire && !soft_rst && !halt_hit |-> !WDG_RESET_N [*5];
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse too short"); // see [RULE3]

  property p_act_sticky;
    @(posedge CLK) disable iff (RST) act_ff |=> act_ff;
  endproperty
  a_act_sticky: assert property (p_act_sticky) else $error("activation bit cleared"); // see [RULE9]

  property p_write_load;
    @(posedge CLK) disable iff (RST) wr_ctrl |=> count_ff == $past(AVS_WRITEDATA[6:0]);
  endproperty
  a_write_load: assert property (p_write_load) else $error("write not loaded"); // see [RULE20]

  property p_frozen_hold;
    @(posedge CLK) disable iff (RST) frozen && !wr_ctrl |=> $stable(count_ff);
  endproperty
  a_frozen_hold: assert property (p_frozen_hold) else $error("counter moved in halt"); // see [RULE13]

  property p_soft_reset;
    @(posedge CLK) disable iff (RST) soft_rst |=> !WDG_RESET_N;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("no software reset"); // see [RULE10]

  property p_inactive_quiet;
    @(posedge CLK) disable iff (RST)
      !active && !soft_rst && WDG_RESET_N |=> WDG_RESET_N;
  endproperty
  a_inactive_quiet: assert property (p_inactive_quiet) else $error("reset while idle"); // see [RULE8]

  property p_suspend_halt;
    @(posedge CLK) disable iff (RST)
      PWR.halt_exec && PWR.usb_suspend && !expire && !soft_rst && WDG_RESET_N
      |=> WDG_RESET_N;
  endproperty
  a_suspend_halt: assert property (p_suspend_halt) else $error("reset in suspend"); // see [RULE15]

  property p_wake_delay;
    @(posedge CLK) disable iff (RST) mode_ff == HALTED && PWR.ext_wake |=> frozen [*8];
  endproperty
  a_wake_delay: assert property (p_wake_delay) else $error("woke too early"); // see [RULE14]

  // ----------------------------------------------------------------
  // counting and power mode checks
  // ----------------------------------------------------------------
  // one step lowers the count by exactly one
  property p_step_count;
    @(posedge CLK) disable iff (RST)
      step && !wr_ctrl |=> count_ff == $past(count_ff) - 7'h01;
  endproperty
  a_step_count: assert property (p_step_count) else $error("count step wrong"); // see [RULE1]

  // prescaler wraps after its last count
  property p_prescale_wrap;
    @(posedge CLK) disable iff (RST)
      !frozen && pre_ff == PRE_LAST |=> pre_ff == '0;
  endproperty
  a_prescale_wrap: assert property (p_prescale_wrap) else $error("prescale stuck"); // see [RULE4]

  // wait mode does not hold back a step
  property p_wait_step;
    @(posedge CLK) disable iff (RST)
      PWR.wait_mode && !frozen && pre_ff == PRE_LAST |-> step;
  endproperty
  a_wait_step: assert property (p_wait_step) else $error("step lost in wait"); // see [RULE12]

  // hardware option expires without the activation bit
  property p_hw_expire;
    @(posedge CLK) disable iff (RST)
      hw_ff && step && count_ff == 7'h40 |=> !WDG_RESET_N;
  endproperty
  a_hw_expire: assert property (p_hw_expire) else $error("no hardware expiry"); // see [RULE11]

  // halt without permit resets an active watchdog
  property p_halt_reset;
    @(posedge CLK) disable iff (RST)
      halt_hit |=> !WDG_RESET_N;
  endproperty
  a_halt_reset: assert property (p_halt_reset) else $error("no reset on halt"); // see [RULE19]

  // permitted halt with stopped oscillator freezes
  property p_halt_enter;
    @(posedge CLK) disable iff (RST)
      mode_ff == RUN && PWR.halt_exec && PWR.osc_stopped && permit_ff |=> frozen;
  endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("halt not frozen"); // see [RULE13]

  // counting resumes once the wake delay runs out
  property p_wake_resume;
    @(posedge CLK) disable iff (RST)
      mode_ff == WAKING && wake_ff == WW'(1) |=> !frozen;
  endproperty
  a_wake_resume: assert property (p_wake_resume) else $error("wake stuck"); // see [RULE14]

  // ----------------------------------------------------------------
  // pulse and bus checks
  // ----------------------------------------------------------------
  // pin stays low while the pulse counter runs
  property p_pulse_hold;
    @(posedge CLK) disable iff (RST)
      pulse_ff > RW'(1) |=> !WDG_RESET_N;
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("pulse cut short"); // see [RULE3]

  // pin returns high at the end of the pulse
  property p_pulse_end;
    @(posedge CLK) disable iff (RST)
      pulse_ff == RW'(1) && !expire && !soft_rst && !halt_hit |=> WDG_RESET_N;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse too long"); // see [RULE3]

  // software reset write also sets the activation bit
  property p_soft_act;
    @(posedge CLK) disable iff (RST)
      soft_rst |=> act_ff;
  endproperty
  a_soft_act: assert property (p_soft_act) else $error("soft reset not active"); // see [RULE10]

  // a taken request is answered in the next cycle
  property p_take_ack;
    @(posedge CLK) disable iff (RST)
      acc |=> !AVS_WAITREQUEST;
  endproperty
  a_take_ack: assert property (p_take_ack) else $error("request not answered");

  // the answer stands for one cycle only
  property p_ack_once;
    @(posedge CLK) disable iff (RST)
      !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("answer held too long");

  c_expire: cover property (@(posedge CLK) disable iff (RST) expire);
  c_soft:   cover property (@(posedge CLK) disable iff (RST) soft_rst);
  c_halt:   cover property (@(posedge CLK) disable iff (RST) halt_hit);
  c_hw:     cover property (@(posedge CLK) disable iff (RST) hw_ff && expire);
  c_wake:   cover property (@(posedge CLK) disable iff (RST) mode_ff == WAKING && wake_ff == WW'(1));

endmodule

// ---- testbench/watchdog_timer_tb_top.sv ----
// bench for watchdog_timer: bus tasks, reset pulse timing, power modes
// assumes shortened prescale and wake delay, one clock domain
module watchdog_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PS = 16;
  localparam int WD = 8;
  localparam logic [7:0] ctl_a = wdg_pkg::WATCHDOG_CONTROL_OFS;
  localparam logic [7:0] misc_a = wdg_pkg::MISC_CONFIG_THREE_OFS;
  logic            CLK, RST, HW_OPTION, AVS_READ, AVS_WRITE;
  logic            AVS_WAITREQUEST, WDG_RESET_N;
  wdg_pkg::power_s PWR;
  logic [7:0]      AVS_ADDRESS, v, a;
  logic [31:0]     AVS_WRITEDATA, AVS_READDATA, rd;
  logic [15:0]     lfsr;
  int              n_errors, checks_done, t, m, k;
  int              mdl_act; // model: activation bit, set-only until reset

  watchdog_timer #(.PRESCALE(PS), .WAKE_DLY(WD)) dut (
    .CLK(CLK), .RST(RST), .HW_OPTION(HW_OPTION), .PWR(PWR),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .WDG_RESET_N(WDG_RESET_N));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(logic w, logic [7:0] ad, logic [7:0] d);
    AVS_ADDRESS <= ad;
    AVS_WRITEDATA <= {24'h0, d};
    AVS_WRITE <= w;
    AVS_READ <= !w;
    t = 0;
    do begin
      @(posedge CLK);
      t++;
    end while (AVS_WAITREQUEST !== 1'b0 && t < 50);
    rd = AVS_READDATA;
    if (w && d[7]) mdl_act = 1;
    if (t >= 50) begin
      n_errors++;
      finish_test();
    end
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic reset_dut;
    mdl_act = 0;
    RST <= 1'b1;
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic wlow(int mx);
    m = 0;
    while (WDG_RESET_N !== 1'b0 && m < mx) begin
      @(posedge CLK);
      m++;
    end
  endtask

  // reset pulse expected between lo and hi cycles from now
  task automatic expect_rst(int lo, int hi, string s);
    wlow(hi + 1);
    chk("reset delay", 1, m >= lo && m <= hi);
    t = 0;
    while (WDG_RESET_N === 1'b0 && t < 99) begin
      @(posedge CLK);
      t++;
    end
    chk("reset width", wdg_pkg::RESET_PULSE_CYC, t);
    $display("test %s done", s);
    reset_dut();
  endtask

  task automatic halt_pulse;
    PWR.halt_exec <= 1'b1;
    @(posedge CLK);
    PWR.halt_exec <= 1'b0;
  endtask

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  initial begin
    repeat (100000) @(posedge CLK);
    n_errors++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    RST = 1'b1;
    HW_OPTION = 1'b0;
    PWR = '0;
    AVS_ADDRESS = 8'h00;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0;
    lfsr = 16'h6fb4;
    n_errors = 0;
    checks_done = 0;
    reset_dut();
    bus(0, ctl_a, 8'h00);
    chk("control reset", 32'h7f, rd);
    bus(0, misc_a, 8'h00);
    chk("misc reset", 32'h0, rd);
    bus(0, 8'h20, 8'h00);
    chk("unmapped read", 32'h0, rd);
    $display("test reset values done");
    // free running count while inactive, one step per prescale
    bus(0, ctl_a, 8'h00);
    a = rd[7:0];
    repeat (PS - 3) @(posedge CLK);
    bus(0, ctl_a, 8'h00);
    chk("step", 32'h1, a - rd[7:0]);
    wlow(64 * PS + 4);
    chk("no reset inactive", 1, WDG_RESET_N);
    $display("test free run done");
    // random start values, clear attempt, expiry; wait mode on
    PWR.wait_mode <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      v = {2'b11, lfsr[5:0]};
      bus(1, ctl_a, v);
      bus(1, ctl_a, v & 8'h7f);
      bus(0, ctl_a, 8'h00);
      chk("active bit", mdl_act, rd[7]);
      chk("count load", 1, rd[6:0] == v[6:0] || rd[6:0] == v[6:0] - 1);
      k = v[5:0] + 1;
      expect_rst((k - 1) * PS - 8, k * PS + 4, "expiry");
    end
    PWR.wait_mode <= 1'b0;
    bus(0, ctl_a, 8'h00);
    chk("inactive after reset", 32'h7f, rd);
    // periodic refresh keeps an active watchdog quiet
    bus(1, ctl_a, 8'hc4);
    for (int i = 0; i < 4; i++) begin
      repeat (PS) @(posedge CLK);
      bus(1, ctl_a, 8'hc4);
    end
    wlow(PS);
    chk("no reset refreshed", 1, WDG_RESET_N);
    $display("test refresh done");
    bus(1, ctl_a, 8'h80);
    expect_rst(0, 3, "software reset");
    HW_OPTION <= 1'b1;
    reset_dut();
    expect_rst(63 * PS - 8, 64 * PS + 4, "hardware option");
    HW_OPTION <= 1'b0;
    reset_dut();
    bus(1, ctl_a, 8'hc8);
    halt_pulse();
    expect_rst(0, 3, "halt no permit");
    PWR.usb_suspend <= 1'b1;
    bus(1, ctl_a, 8'hc8);
    halt_pulse();
    wlow(8);
    chk("no reset suspend", 1, WDG_RESET_N);
    PWR.usb_suspend <= 1'b0;
    $display("test suspend done");
    // halt permitted with stopped oscillator freezes, wake resumes
    bus(1, misc_a, 8'h80);
    bus(1, ctl_a, 8'hff);
    PWR.osc_stopped <= 1'b1;
    halt_pulse();
    bus(0, ctl_a, 8'h00);
    a = rd[7:0];
    wlow(3 * PS);
    bus(0, ctl_a, 8'h00);
    chk("frozen", a, rd[7:0]);
    chk("no reset halted", 1, WDG_RESET_N);
    PWR.osc_stopped <= 1'b0;
    PWR.ext_wake <= 1'b1;
    @(posedge CLK);
    PWR.ext_wake <= 1'b0;
    bus(0, ctl_a, 8'h00);
    chk("wake delay", a, rd[7:0]);
    repeat (WD + 2 * PS) @(posedge CLK);
    bus(0, ctl_a, 8'h00);
    chk("resumed", 1, a - rd[7:0] >= 1 && a - rd[7:0] <= 3);
    $display("test halt done");
    finish_test();
  end
endmodule
